// [dpm_regs.svh]
// constants for the dual-port memory host port controller
// Behaviour
// - host keeps write strobe high during address changes
// - host reads with select and output enable low
// - host uses token select for token latches
// - token and array selects never low together
// - host waits flow-through delay before trusting reads
// - host releases token select before token read-back
`ifndef DPM_REGS_SVH
`define DPM_REGS_SVH

// ---------------------------------------------------------------
// widths and addresses
// ---------------------------------------------------------------
`define DPM_ADDR_W        14
`define DPM_DATA_W        9
`define DPM_MBOX_TOP      14'h3FFF
`define DPM_MBOX_NEXT     14'h3FFE
`define DPM_TOKEN_MASK    14'h0007

// ---------------------------------------------------------------
// timing, in ns and in ref_clk cycles
// ---------------------------------------------------------------
`define DPM_CLK_NS        10
`define DPM_T_PWE_NS      12
`define DPM_T_DDD_NS      25
`define DPM_T_SOP_NS      10
`define DPM_SYNC_STAGES   2
`define DPM_PWE_CYC       ((`DPM_T_PWE_NS + `DPM_CLK_NS - 1) / `DPM_CLK_NS)
`define DPM_SOP_CYC       ((`DPM_T_SOP_NS + `DPM_CLK_NS - 1) / `DPM_CLK_NS)
`define DPM_RD_CYC        (((`DPM_T_DDD_NS + `DPM_CLK_NS - 1) / `DPM_CLK_NS) + `DPM_SYNC_STAGES)

`endif

// [dpm_pkg.sv]
// types of the dual-port memory host port controller
package dpm_pkg;

  typedef enum logic [1:0] {
    DPM_OP_READ      = 2'h0,
    DPM_OP_WRITE     = 2'h1,
    DPM_OP_TOK_WRITE = 2'h2,
    DPM_OP_TOK_REQ   = 2'h3
  } dpm_op_t;

  typedef enum logic [2:0] {
    DPM_IDLE     = 3'h0,
    DPM_SETUP    = 3'h1,
    DPM_WR_PULSE = 3'h2,
    DPM_WR_END   = 3'h3,
    DPM_SEM_GAP  = 3'h4,
    DPM_RD_WAIT  = 3'h5
  } dpm_state_t;

  typedef struct packed {
    dpm_state_t  state;
    logic [3:0]  cnt;
    logic        tokReq;
    logic        busySeen;
    logic        ceN;
    logic        semN;
    logic        rwN;
    logic        oeN;
    logic [13:0] addr;
    logic [8:0]  dataOut;
    logic        dataOe;
    logic        ready;
    logic        rspValid;
    logic        rspContended;
    logic [8:0]  rspData;
    logic        mailbox;
  } dpm_host_s_t;

endpackage

// [dpm_sync2.sv]
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module dpm_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  // asynchronous level in, synchronised level out
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1  <= '1;
      syncOut <= '1;
    end else begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule

// [dpm_host.sv]
// host controller driving one port of the dual-port memory
`timescale 1ns/10ps
`include "dpm_regs.svh"
module dpm_host (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   reset_n,
  // user command port
  input  wire logic                   cmdValid,
  output logic                        cmdReady,
  input  wire dpm_pkg::dpm_op_t       cmdOp,
  input  wire logic [`DPM_ADDR_W-1:0] cmdAddr,
  input  wire logic [`DPM_DATA_W-1:0] cmdData,
  // user response port
  output logic                        rspValid,
  output logic [`DPM_DATA_W-1:0]      rspData,
  output logic                        rspContended,
  // mailbox status
  output logic                        mailboxPending,
  // memory port selects and strobes
  output logic                        chipSelN,
  output logic                        tokenSelN,
  output logic                        rwSelN,
  output logic                        outDriveN,
  // memory address and data pins
  output logic [`DPM_ADDR_W-1:0]      memAddr,
  input  wire logic [`DPM_DATA_W-1:0] memDataIn,
  output logic [`DPM_DATA_W-1:0]      memDataOut,
  output logic                        memDataOe,
  // memory flag pins
  input  wire logic                   contendN,
  input  wire logic                   mailboxIntN
);

  // ---------------------------------------------------------------
  // timing counts, rounded up to whole clock cycles
  // ---------------------------------------------------------------
  localparam logic [3:0] PWE_CYC = 4'(`DPM_PWE_CYC);
  localparam logic [3:0] SOP_CYC = 4'(`DPM_SOP_CYC);
  localparam logic [3:0] RD_CYC  = 4'(`DPM_RD_CYC);

  dpm_pkg::dpm_host_s_t s;
  dpm_pkg::dpm_host_s_t next_s;

  logic [`DPM_DATA_W-1:0] dataSync;
  logic                   contendSyncN;
  logic                   intSyncN;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic isToken(input dpm_pkg::dpm_op_t op);
    isToken = (op == dpm_pkg::DPM_OP_TOK_WRITE) || (op == dpm_pkg::DPM_OP_TOK_REQ);
  endfunction

  // a wait ends on the edge where the count reads one
  function automatic logic cntLast(input logic [3:0] cnt);
    cntLast = (cnt == 4'h1);
  endfunction

  function automatic logic [3:0] cntDown(input logic [3:0] cnt);
    cntDown = cnt - 4'h1;
  endfunction

  // ---------------------------------------------------------------
  // pin input synchronisers
  // ---------------------------------------------------------------
  dpm_sync2 #(
    .WIDTH(`DPM_DATA_W + 2)
  ) u_sync (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .asyncIn ({memDataIn, contendN, mailboxIntN}),
    .syncOut ({dataSync, contendSyncN, intSyncN})
  );

  // ---------------------------------------------------------------
  // access sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_s          = s;
    next_s.rspValid = 1'b0;
    next_s.mailbox  = ~intSyncN;
    unique case (s.state)
      dpm_pkg::DPM_IDLE: begin
        if (cmdValid) begin
          // address moves only while the write strobe is high
          if (isToken(cmdOp)) begin
            // upper lines forced low so a token access never aliases a word
            next_s.addr    = cmdAddr & `DPM_TOKEN_MASK;
            // token writes copy the lowest command data bit onto every data line
            next_s.dataOut = {`DPM_DATA_W{cmdData[0]}};
            // one select only, the other held high
            next_s.semN    = 1'b0;
            next_s.ceN     = 1'b1;
          end else begin
            next_s.addr    = cmdAddr;
            next_s.dataOut = cmdData;
            next_s.semN    = 1'b1;
            next_s.ceN     = 1'b0;
          end
          next_s.tokReq   = (cmdOp == dpm_pkg::DPM_OP_TOK_REQ);
          next_s.busySeen = 1'b0;
          next_s.ready    = 1'b0;
          if (cmdOp == dpm_pkg::DPM_OP_READ) begin
            next_s.oeN   = 1'b0;
            next_s.cnt   = RD_CYC;
            next_s.state = dpm_pkg::DPM_RD_WAIT;
          end else begin
            next_s.state = dpm_pkg::DPM_SETUP;
          end
        end
      end
      dpm_pkg::DPM_SETUP: begin
        next_s.rwN    = 1'b0;
        next_s.dataOe = 1'b1;
        next_s.cnt    = PWE_CYC;
        next_s.state  = dpm_pkg::DPM_WR_PULSE;
      end
      dpm_pkg::DPM_WR_PULSE: begin
        // contended write is held off by the device; stretch until it clears
        if (!contendSyncN && s.ceN == 1'b0) begin
          next_s.busySeen = 1'b1;
          next_s.cnt      = PWE_CYC;
        end else if (cntLast(s.cnt)) begin
          next_s.rwN   = 1'b1;
          next_s.state = dpm_pkg::DPM_WR_END;
        end else begin
          next_s.cnt = cntDown(s.cnt);
        end
      end
      dpm_pkg::DPM_WR_END: begin
        next_s.dataOe = 1'b0;
        next_s.semN   = 1'b1;
        if (s.tokReq) begin
          // token select released for the update pulse before read-back
          next_s.cnt   = SOP_CYC;
          next_s.state = dpm_pkg::DPM_SEM_GAP;
        end else begin
          next_s.ceN          = 1'b1;
          next_s.rspValid     = 1'b1;
          next_s.rspContended = s.busySeen;
          next_s.ready        = 1'b1;
          next_s.state        = dpm_pkg::DPM_IDLE;
        end
      end
      dpm_pkg::DPM_SEM_GAP: begin
        if (cntLast(s.cnt)) begin
          next_s.semN  = 1'b0;
          next_s.oeN   = 1'b0;
          next_s.cnt   = RD_CYC;
          next_s.state = dpm_pkg::DPM_RD_WAIT;
        end else begin
          next_s.cnt = cntDown(s.cnt);
        end
      end
      dpm_pkg::DPM_RD_WAIT: begin
        if (!contendSyncN && s.ceN == 1'b0) begin
          next_s.busySeen = 1'b1;
        end
        // waiting the flow-through delay plus sync stages covers a racing write
        if (cntLast(s.cnt)) begin
          next_s.rspData      = dataSync;
          next_s.oeN          = 1'b1;
          next_s.ceN          = 1'b1;
          next_s.semN         = 1'b1;
          next_s.rspValid     = 1'b1;
          next_s.rspContended = s.busySeen;
          next_s.ready        = 1'b1;
          next_s.state        = dpm_pkg::DPM_IDLE;
        end else begin
          next_s.cnt = cntDown(s.cnt);
        end
      end
      default: begin
        next_s       = s;
        next_s.state = dpm_pkg::DPM_IDLE;
        next_s.ceN   = 1'b1;
        next_s.semN  = 1'b1;
        next_s.rwN   = 1'b1;
        next_s.oeN   = 1'b1;
        next_s.ready = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state register; every pin strobe parks high in reset
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s.state        <= dpm_pkg::DPM_IDLE;
      s.cnt          <= 4'h0;
      s.tokReq       <= 1'b0;
      s.busySeen     <= 1'b0;
      s.ceN          <= 1'b1;
      s.semN         <= 1'b1;
      s.rwN          <= 1'b1;
      s.oeN          <= 1'b1;
      s.addr         <= 14'h0000;
      s.dataOut      <= 9'h000;
      s.dataOe       <= 1'b0;
      s.ready        <= 1'b1;
      s.rspValid     <= 1'b0;
      s.rspContended <= 1'b0;
      s.rspData      <= 9'h000;
      s.mailbox      <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all straight from the state register
  // ---------------------------------------------------------------
  assign cmdReady       = s.ready;
  assign rspValid       = s.rspValid;
  assign rspData        = s.rspData;
  assign rspContended   = s.rspContended;
  assign mailboxPending = s.mailbox;
  assign chipSelN       = s.ceN;
  assign tokenSelN      = s.semN;
  assign rwSelN         = s.rwN;
  assign outDriveN      = s.oeN;
  assign memAddr        = s.addr;
  assign memDataOut     = s.dataOut;
  assign memDataOe      = s.dataOe;

endmodule

// [dpm_host_monitor.sv]
// pin-level checker for the memory host port controller
`timescale 1ns/10ps
module dpm_host_monitor (
  // clock, reset, command side
  input wire logic             ref_clk,
  input wire logic             reset_n,
  input wire logic             cmdValid,
  input wire logic             cmdReady,
  input wire dpm_pkg::dpm_op_t cmdOp,
  input wire logic             rspValid,
  input wire logic             rspContended,
  input wire logic             mailboxPending,
  // memory pins
  input wire logic             chipSelN,
  input wire logic             tokenSelN,
  input wire logic             rwSelN,
  input wire logic             outDriveN,
  input wire logic [13:0]      memAddr,
  input wire logic             memDataOe,
  input wire logic             mailboxIntN
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic take;
  assign take = cmdValid && cmdReady;
  property p_rw_addr; !rwSelN |-> $stable(memAddr); endproperty
  a_rw_addr: assert property (p_rw_addr) else $error("address moved in write");
  property p_sel_excl; !(!chipSelN && !tokenSelN); endproperty
  a_sel_excl: assert property (p_sel_excl) else $error("both selects low");
  property p_wr_seq; take && cmdOp == dpm_pkg::DPM_OP_WRITE |=> rwSelN && !chipSelN ##1 !rwSelN;
  endproperty
  a_wr_seq: assert property (p_wr_seq) else $error("write strobe order wrong");
  property p_rd_lat; take && cmdOp == dpm_pkg::DPM_OP_READ |=> !rspValid[*3] ##[1:3] rspValid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answered too early or late");
  property p_idle; cmdReady |-> chipSelN && tokenSelN && !memDataOe && outDriveN; endproperty
  a_idle: assert property (p_idle) else $error("pins active while idle");
  property p_drive; !outDriveN |-> rwSelN && !memDataOe; endproperty
  a_drive: assert property (p_drive) else $error("read enable during write");
  property p_tok_gap; !tokenSelN && $fell(outDriveN) |-> $past(tokenSelN); endproperty
  a_tok_gap: assert property (p_tok_gap) else $error("no token select gap");
  property p_mbox; $fell(mailboxIntN) |-> ##[2:4] mailboxPending; endproperty
  a_mbox: assert property (p_mbox) else $error("mailbox flag not followed");
  c_tok: cover property (take && cmdOp == dpm_pkg::DPM_OP_TOK_REQ);
  c_con: cover property (rspValid && rspContended);
  c_mbox: cover property ($rose(mailboxIntN));
endmodule

bind dpm_host dpm_host_monitor u_mon (.ref_clk, .reset_n, .cmdValid, .cmdReady, .cmdOp,
  .rspValid, .rspContended, .mailboxPending, .chipSelN, .tokenSelN, .rwSelN, .outDriveN,
  .memAddr, .memDataOe, .mailboxIntN);

// [dpm_mem_model.sv]
// behavioural memory device on the far side of one host port
`timescale 1ns/10ps
`include "dpm_regs.svh"
module dpm_mem_model (
  // host pins
  input  wire logic        chipSelN,
  input  wire logic        tokenSelN,
  input  wire logic        rwSelN,
  input  wire logic        outDriveN,
  input  wire logic [13:0] memAddr,
  input  wire logic [8:0]  memDataOut,
  input  wire logic        memDataOe,
  input  wire logic        contendN,
  // other port's actions
  input  wire logic        farMailbox,
  input  wire logic        farOwn,
  // back to host
  output logic [8:0]       memDataIn,
  output logic             mailboxIntN = 1'b1
);
  logic [8:0] mem [16384];
  logic [7:0] own = 8'h00;
  // far port's flag; set by a write to the top word, nothing here clears it
  logic       farInt = 1'b0;
  logic [8:0] lastVal = 9'h0AA;
  logic       drive;
  logic       clr;
  assign drive = rwSelN && !outDriveN && (chipSelN != tokenSelN);
  // released lines show the inverse so stale data never looks valid
  assign memDataIn = memDataOe ? memDataOut : drive ? (!tokenSelN ?
    {9{!own[memAddr[2:0]]}} : mem[memAddr]) : ~lastVal;
  always @(memDataIn) if (drive || memDataOe) lastVal = memDataIn;
  always @(posedge rwSelN) begin
    if (!chipSelN && contendN) mem[memAddr] <= memDataOut;
    if (!chipSelN && memAddr == `DPM_MBOX_TOP) farInt <= 1'b1;
    if (!tokenSelN && memDataOut[0]) own[memAddr[2:0]] <= 1'b0;
    else if (!tokenSelN && !farOwn) own[memAddr[2:0]] <= 1'b1;
  end
  assign clr = drive && !chipSelN && memAddr == `DPM_MBOX_NEXT;
  always @(posedge farMailbox or posedge clr) mailboxIntN <= clr;
endmodule

// [dpm_host_tb_top.sv]
// self-checking bench for the memory host port controller
`timescale 1ns/10ps
module dpm_host_tb_top;
  logic             ref_clk = 1'b0;
  logic             reset_n = 1'b0;
  logic             cmdValid = 1'b0;
  dpm_pkg::dpm_op_t cmdOp = dpm_pkg::DPM_OP_READ;
  logic [13:0]      cmdAddr = 14'h0000;
  logic [8:0]       cmdData = 9'h000;
  logic             contendN = 1'b1;
  logic             farMailbox = 1'b0;
  logic             farOwn = 1'b0;
  logic             cmdReady, rspValid, rspContended, mailboxPending, mailboxIntN;
  logic             chipSelN, tokenSelN, rwSelN, outDriveN, memDataOe;
  logic [13:0]      memAddr;
  logic [8:0]       memDataIn, memDataOut, got, d;
  logic [13:0]      a;
  logic [8:0]       refMem [int];
  int               err_total = 0;
  int               tests_run = 0;
  dpm_host DUT (.ref_clk, .reset_n, .cmdValid, .cmdReady, .cmdOp, .cmdAddr, .cmdData,
    .rspValid, .rspData(got), .rspContended, .mailboxPending, .chipSelN, .tokenSelN,
    .rwSelN, .outDriveN, .memAddr, .memDataIn, .memDataOut, .memDataOe, .contendN,
    .mailboxIntN);
  dpm_mem_model u_mem (.chipSelN, .tokenSelN, .rwSelN, .outDriveN, .memAddr, .memDataOut,
    .memDataOe, .contendN, .farMailbox, .farOwn, .memDataIn, .mailboxIntN);
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string name, logic [8:0] exp, logic [8:0] act);
    tests_run++;
    if (act !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, act);
    end
  endtask
  task automatic chkFlag(string name, logic exp, logic act);
    chk(name, {8'h00, exp}, {8'h00, act});
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // bounded wait; the edge that sees sig high is the one that counts
  task automatic waitHigh(ref logic sig);
    for (int n = 0; n <= 60; n++) begin
      @(posedge ref_clk);
      if (sig === 1'b1) return;
    end
    chkFlag("handshake", 1'b1, sig);
    end_of_test();
  endtask
  task automatic cmd(dpm_pkg::dpm_op_t op, logic [13:0] ad, logic [8:0] dt);
    cmdOp = op;
    cmdAddr = ad;
    cmdData = dt;
    cmdValid = 1'b1;
    waitHigh(cmdReady);
    #1 cmdValid = 1'b0;
    waitHigh(rspValid);
    d = got;
    #1;
  endtask
  initial begin
    void'($urandom(32'hB14E));
    cyc(20);
    reset_n = 1'b1;
    for (int i = 0; i < 10; i++) begin
      a = (i < 2) ? 14'h3FFE + 14'(i) : 14'($urandom_range(16383));
      refMem[a] = 9'($urandom);
      cmd(dpm_pkg::DPM_OP_WRITE, a, refMem[a]);
      cmd(dpm_pkg::DPM_OP_READ, a, 9'h000);
      chk("read data", refMem[a], d);
      chkFlag("contention", 1'b0, rspContended);
    end
    chkFlag("far mailbox", 1'b1, u_mem.farInt);
    contendN = 1'b0;
    fork
      begin
        cyc(6);
        contendN = 1'b1;
      end
    join_none
    cmd(dpm_pkg::DPM_OP_WRITE, 14'h0123, 9'h1A5);
    chkFlag("contention", 1'b1, rspContended);
    cmd(dpm_pkg::DPM_OP_READ, 14'h0123, 9'h000);
    chk("read data", 9'h1A5, d);
    farMailbox = 1'b1;
    cyc(6);
    chkFlag("mailbox", 1'b1, mailboxPending);
    farMailbox = 1'b0;
    cmd(dpm_pkg::DPM_OP_READ, 14'h3FFE, 9'h000);
    chk("read data", refMem[14'h3FFE], d);
    cyc(6);
    chkFlag("mailbox", 1'b0, mailboxPending);
    cmd(dpm_pkg::DPM_OP_TOK_REQ, 14'h3FF5, 9'h000);
    chk("token", 9'h000, d);
    farOwn = 1'b1;
    cmd(dpm_pkg::DPM_OP_TOK_REQ, 14'h0002, 9'h000);
    chk("token", 9'h1FF, d);
    cmd(dpm_pkg::DPM_OP_TOK_WRITE, 14'h0005, 9'h001);
    farOwn = 1'b0;
    cmd(dpm_pkg::DPM_OP_TOK_REQ, 14'h0005, 9'h1FE);
    chk("token", 9'h000, d);
    end_of_test();
  end
endmodule
